// *** rtl/e1_national_bit_buffers.sv ***
// Transmit and receive national spare-bit buffers with APB register access
//
// Implementation choice: the APB register port.
`include "nbb_cfg.svh"
`default_nettype none
module e1_national_bit_buffers
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire nbb_pkg::apb_req_s apb_req,
   output nbb_pkg::apb_rsp_s apb_rsp,
   input wire logic crc4_mf_active,
   input wire nbb_pkg::ts0_event_s tx_ts0,
   output logic [4:0] tx_spare_bits,
   output logic tx_spare_insert,
   input wire nbb_pkg::ts0_event_s rx_ts0,
   output logic rx_spare_ready
);
   import nbb_pkg::*;

   // ***************************************************************
   // Helpers
   // ***************************************************************

   // Slot 0 is frame 1; with CRC-4 the slot comes from the frame number,
   // otherwise from a running count of odd frames
   function automatic logic [`NBB_SLOT_W-1:0] frame_slot
   (
      input logic crc4,
      input logic [3:0] frame_num,
      input logic [`NBB_SLOT_W-1:0] running
   );
      logic [`NBB_SLOT_W-1:0] s;
      s = crc4 ? frame_num[3:1] : running;
      return s;
   endfunction

   // Bit within a byte: earliest frame lands in the top bit
   function automatic logic [`NBB_SLOT_W-1:0] slot_bit
   (
      input logic [`NBB_SLOT_W-1:0] slot
   );
      logic [`NBB_SLOT_W-1:0] b;
      b = `NBB_SLOT_MSB_BIT - slot;
      return b;
   endfunction

   // Check that a buffer offset falls on one of the five bytes, 0x10..0x14
   function automatic logic in_buffer_range
   (
      input logic [4:0] ofs
   );
      logic r;
      r = (ofs >= `NBB_OFS_FIRST) && (ofs <= `NBB_OFS_LAST);
      return r;
   endfunction

   // ***************************************************************
   // Storage
   // ***************************************************************

   spare_byte_t tx_spare_bit_buffer_r [`NBB_NUM_BYTES];
   spare_byte_t rx_spare_bit_buffer_r [`NBB_NUM_BYTES];
   logic spare_buffer_tx_enable_r;
   logic [`NBB_SLOT_W-1:0] tx_run_r;
   logic [`NBB_SLOT_W-1:0] rx_run_r;
   logic [4:0] tx_bits_r;
   logic tx_insert_r;
   logic rx_ready_r;
   apb_rsp_s rsp_r;

   // ***************************************************************
   // APB decode
   // ***************************************************************

   wire [`NBB_IDX_W-1:0] reg_idx = apb_req.paddr[11:2];
   wire [4:0] reg_page = reg_idx[9:5];
   wire [4:0] reg_ofs = reg_idx[4:0];
   wire [`NBB_BYTE_SEL_W-1:0] byte_sel = `NBB_BYTE_SEL_W'(reg_ofs - `NBB_OFS_FIRST);
   wire word_aligned = (apb_req.paddr[1:0] == 2'h0);
   wire hit_tx = word_aligned && (reg_page == `NBB_PAGE_TX) && in_buffer_range(reg_ofs);
   wire hit_rx = word_aligned && (reg_page == `NBB_PAGE_RX) && in_buffer_range(reg_ofs);
   wire hit_ctrl = word_aligned && (reg_page == `NBB_PAGE_CTRL) && (reg_ofs == `NBB_OFS_CTRL);
   wire hit_stat = word_aligned && (reg_page == `NBB_PAGE_CTRL) && (reg_ofs == `NBB_OFS_STAT);
   wire hit_any = hit_tx || hit_rx || hit_ctrl || hit_stat;
   wire apb_access = apb_req.psel && apb_req.penable;
   wire apb_first = apb_access && !rsp_r.pready;
   wire apb_done = apb_access && rsp_r.pready;
   wire wr_commit = apb_done && apb_req.pwrite && hit_any;
   wire wr_tx = wr_commit && hit_tx;
   wire wr_ctrl = wr_commit && hit_ctrl;

   // Status: FIFO level and the current alignment mode
   logic [`NBB_FIFO_LVL_W-1:0] fifo_level;
   wire [31:0] stat_word = (32'(fifo_level) << `NBB_STAT_LVL_LSB)
      | (32'(crc4_mf_active) << `NBB_STAT_CRC4_BIT);
   wire [31:0] ctrl_word = 32'(spare_buffer_tx_enable_r) << `NBB_CTRL_TXEN_BIT;

   // Receive bytes read as a consistent snapshot only because the FIFO drain
   // is held off for the whole transfer
   wire [31:0] rd_word =
      hit_tx ? 32'(tx_spare_bit_buffer_r[byte_sel]) :
      hit_rx ? 32'(rx_spare_bit_buffer_r[byte_sel]) :
      hit_ctrl ? ctrl_word :
      hit_stat ? stat_word :
      32'h0000_0000;

   // Registered answer: one wait state on every access
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rsp_r <= '0;
      end
      else
      begin
         rsp_r.pready <= apb_first;
         rsp_r.pslverr <= apb_first && !hit_any;
         if (apb_first && !apb_req.pwrite)
         begin
            rsp_r.prdata <= rd_word;
         end
      end
   end

   // ***************************************************************
   // Control register
   // ***************************************************************

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         spare_buffer_tx_enable_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         spare_buffer_tx_enable_r <= apb_req.pwdata[`NBB_CTRL_TXEN_BIT];
      end
   end

   // ***************************************************************
   // Transmit path
   // ***************************************************************

   wire [`NBB_SLOT_W-1:0] tx_slot = frame_slot(crc4_mf_active, tx_ts0.frame_num, tx_run_r);
   wire [`NBB_SLOT_W-1:0] tx_bit = slot_bit(tx_slot);
   logic [4:0] tx_pick;

   always_comb
   begin
      tx_pick = '0;
      for (int k = 0; k < `NBB_NUM_BYTES; k++)
      begin
         tx_pick[k] = tx_spare_bit_buffer_r[k][tx_bit];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         for (int k = 0; k < `NBB_NUM_BYTES; k++)
         begin
            tx_spare_bit_buffer_r[k] <= '0;
         end
      end
      else if (wr_tx)
      begin
         tx_spare_bit_buffer_r[byte_sel] <= apb_req.pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         tx_run_r <= '0;
         tx_bits_r <= '0;
         tx_insert_r <= 1'b0;
      end
      else if (tx_ts0.strobe)
      begin
         tx_run_r <= tx_slot + `NBB_SLOT_W'(1);
         tx_bits_r <= tx_pick;
         tx_insert_r <= spare_buffer_tx_enable_r;
      end
   end

   assign tx_spare_bits = tx_bits_r;
   assign tx_spare_insert = tx_insert_r;

   // ***************************************************************
   // Receive path
   // ***************************************************************

   // Capture is decoupled from the buffer so software reads never lose a frame
   wire [`NBB_SLOT_W-1:0] rx_slot = frame_slot(crc4_mf_active, rx_ts0.frame_num, rx_run_r);
   spare_word_s rx_push_word;
   spare_word_s rx_pop_word;
   logic rx_push_ready;
   logic rx_pop_valid;
   wire rx_pop_ready = !(apb_req.psel && hit_rx);

   assign rx_push_word.slot = rx_slot;
   assign rx_push_word.bits = rx_ts0.bits;

   spare_fifo
   #(
      .WIDTH($bits(spare_word_s)),
      .DEPTH(`NBB_FIFO_DEPTH),
      .AW(`NBB_FIFO_AW)
   )
   u_rx_fifo
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(rx_ts0.strobe),
      .in_ready(rx_push_ready),
      .in_data(rx_push_word),
      .out_valid(rx_pop_valid),
      .out_ready(rx_pop_ready),
      .out_data(rx_pop_word),
      .level(fifo_level)
   );

   wire rx_pop = rx_pop_valid && rx_pop_ready;
   wire [`NBB_SLOT_W-1:0] rx_bit = slot_bit(rx_pop_word.slot);

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rx_run_r <= '0;
      end
      else if (rx_ts0.strobe && rx_push_ready)
      begin
         rx_run_r <= rx_slot + `NBB_SLOT_W'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         for (int k = 0; k < `NBB_NUM_BYTES; k++)
         begin
            rx_spare_bit_buffer_r[k] <= '0;
         end
      end
      else if (rx_pop)
      begin
         for (int k = 0; k < `NBB_NUM_BYTES; k++)
         begin
            rx_spare_bit_buffer_r[k][rx_bit] <= rx_pop_word.bits[k];
         end
      end
   end

   // Ready leads the real space by one word, since it is registered
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rx_ready_r <= 1'b0;
      end
      else
      begin
         rx_ready_r <= (fifo_level < `NBB_FIFO_HEADROOM);
      end
   end

   assign rx_spare_ready = rx_ready_r;
   assign apb_rsp = rsp_r;

endmodule
`default_nettype wire

// *** inc/nbb_cfg.svh ***
// Address map, field positions and sizes of the spare-bit buffers
`ifndef NBB_CFG_SVH
`define NBB_CFG_SVH

// Register index = {page, offset}; the byte address is four times the index
`define NBB_IDX_W 10
`define NBB_PAGE_CTRL 5'h01
`define NBB_PAGE_TX 5'h0D
`define NBB_PAGE_RX 5'h0E
`define NBB_OFS_FIRST 5'h10
`define NBB_OFS_LAST 5'h14
`define NBB_OFS_CTRL 5'h10
`define NBB_OFS_STAT 5'h11
`define NBB_NUM_BYTES 5
`define NBB_BYTE_SEL_W 3
`define NBB_CTRL_TXEN_BIT 0
`define NBB_STAT_CRC4_BIT 0
`define NBB_STAT_LVL_LSB 8
`define NBB_SLOT_W 3
`define NBB_SLOT_MSB_BIT 3'h7
`define NBB_FIFO_DEPTH 16
`define NBB_FIFO_AW 4
`define NBB_FIFO_LVL_W 5
`define NBB_FIFO_HEADROOM 5'h0F

`endif

// *** inc/nbb_pkg.sv ***
// Types shared by the spare-bit buffer block, its checker and its test bench
`default_nettype none
package nbb_pkg;

   typedef struct packed
   {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   // One odd (non-alignment) frame timeslot-zero event from the framer
   typedef struct packed
   {
      logic strobe;
      logic [3:0] frame_num;
      logic [4:0] bits;
   } ts0_event_s;

   // Word held in the receive FIFO: target bit slot plus five captured bits
   typedef struct packed
   {
      logic [2:0] slot;
      logic [4:0] bits;
   } spare_word_s;

   typedef logic [7:0] spare_byte_t;

endpackage
`default_nettype wire

// *** rtl/spare_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a fill level
`default_nettype none
module spare_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Full only when all DEPTH words are held; the count is one bit wider than the pointers
   assign in_ready = (count_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign level = count_r;

   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule
`default_nettype wire

// *** test/nbb_sva.sv ***
// Port checker for the spare-bit buffer block
`include "nbb_cfg.svh"
`default_nettype none
module nbb_sva
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire nbb_pkg::apb_req_s apb_req,
   input wire nbb_pkg::apb_rsp_s apb_rsp,
   input wire logic crc4_mf_active,
   input wire nbb_pkg::ts0_event_s tx_ts0,
   input wire logic [4:0] tx_spare_bits,
   input wire logic tx_spare_insert,
   input wire nbb_pkg::ts0_event_s rx_ts0,
   input wire logic rx_spare_ready
);
   import nbb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire logic first_acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
   // ****
   // Bus answers
   // ****
   one_wait_a: assert property (first_acc |=> apb_rsp.pready) else $error("pready late");
   ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
   ready_cause_a: assert property (apb_rsp.pready |-> $past(first_acc)) else $error("pready unasked");
   err_align_a: assert property (first_acc && apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr)
      else $error("misaligned accepted");
   err_gap_a: assert property (first_acc && apb_req.paddr[11:2] == {`NBB_PAGE_TX, 5'h15}
      |=> apb_rsp.pslverr) else $error("sixth byte accepted");
   err_zero_a: assert property (apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
      else $error("refused read not zero");
   byte_wide_a: assert property (apb_rsp.pready && !apb_req.pwrite
      && apb_req.paddr[11:2] != {`NBB_PAGE_CTRL, `NBB_OFS_STAT} |-> apb_rsp.prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   // Transmit line outputs may only move on a frame event
   tx_hold_a: assert property (!tx_ts0.strobe |=> $stable(tx_spare_bits) && $stable(tx_spare_insert))
      else $error("tx bits moved");
   cover property (first_acc ##1 apb_rsp.pslverr);
   cover property (tx_ts0.strobe ##1 tx_spare_insert);
   cover property ($fell(rx_spare_ready));
endmodule
bind e1_national_bit_buffers nbb_sva chk_u (.clk_sys(clk_sys), .srst(srst), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .crc4_mf_active(crc4_mf_active), .tx_ts0(tx_ts0), .tx_spare_bits(tx_spare_bits),
   .tx_spare_insert(tx_spare_insert), .rx_ts0(rx_ts0), .rx_spare_ready(rx_spare_ready));
`default_nettype wire

// *** test/spare_framer.sv ***
// Behavioural line framer issuing timeslot-zero events
`default_nettype none
module spare_framer
(
   input wire logic clk_sys,
   output var nbb_pkg::ts0_event_s tx_ts0,
   output var nbb_pkg::ts0_event_s rx_ts0,
   input wire logic [4:0] tx_spare_bits,
   input wire logic tx_spare_insert,
   input wire logic rx_spare_ready
);
   import nbb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      tx_ts0 = '0;
      rx_ts0 = '0;
   end
   task automatic tx_frame(input logic [3:0] fn, output logic [5:0] got);
      tx_ts0 <= '{1'b1, fn, ~tx_ts0.bits};
      @(posedge clk_sys);
      tx_ts0.strobe <= 1'b0;
      @(posedge clk_sys);
      got = {tx_spare_insert, tx_spare_bits};
   endtask
   // Strobes only while ready; released bits flip so stale data never looks valid
   // Only the bench watchdog ends a wait for ready
   task automatic rx_frame(input logic [3:0] fn, input logic [4:0] b);
      while (rx_spare_ready !== 1'b1)
      begin
         @(posedge clk_sys);
      end
      rx_ts0 <= '{1'b1, fn, b};
      @(posedge clk_sys);
      rx_ts0 <= '{1'b0, fn, ~b};
      @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// *** test/e1_national_bit_buffers_tb.sv ***
// Self-checking bench for the spare-bit buffer block
`include "nbb_cfg.svh"
`default_nettype none
module e1_national_bit_buffers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import nbb_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic crc4_mf_active = 1'b0;
   apb_req_s apb_req = '0;
   apb_rsp_s apb_rsp;
   ts0_event_s tx_ts0;
   ts0_event_s rx_ts0;
   logic [4:0] tx_spare_bits;
   logic tx_spare_insert;
   logic rx_spare_ready;
   int fails = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic err;
   always #2.5 clk_sys = ~clk_sys;
   e1_national_bit_buffers dut_u (.clk_sys(clk_sys), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .crc4_mf_active(crc4_mf_active), .tx_ts0(tx_ts0), .tx_spare_bits(tx_spare_bits),
      .tx_spare_insert(tx_spare_insert), .rx_ts0(rx_ts0), .rx_spare_ready(rx_spare_ready));
   spare_framer framer_u (.clk_sys(clk_sys), .tx_ts0(tx_ts0), .rx_ts0(rx_ts0), .tx_spare_bits(tx_spare_bits),
      .tx_spare_insert(tx_spare_insert), .rx_spare_ready(rx_spare_ready));
   // ****
   // Helpers
   // ****
   function automatic logic [11:0] adr(input logic [4:0] page, input int ofs);
      return {page, 5'(ofs), 2'h0};
   endfunction
   function automatic logic [7:0] tbyte(input int k);
      return 8'(8'h5A + k * 8'h2B);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Keep chains the next setup straight on, holding psel high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic keep = 1'b0);
      apb_req.psel <= 1'b1;
      apb_req.pwrite <= wr;
      apb_req.paddr <= a;
      apb_req.pwdata <= wd;
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
      end
      while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.penable <= 1'b0;
      if (!keep)
      begin
         apb_req.psel <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task automatic do_reset;
      srst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_regs;
      apb(0, adr(`NBB_PAGE_CTRL, `NBB_OFS_CTRL), 0);
      chk(rd, 0);
      for (int k = 0; k < `NBB_NUM_BYTES; k++)
         apb(1, adr(`NBB_PAGE_TX, `NBB_OFS_FIRST + k), {24'h0, tbyte(k)}, 1'b1);
      for (int k = 0; k < `NBB_NUM_BYTES; k++)
      begin
         apb(0, adr(`NBB_PAGE_TX, `NBB_OFS_FIRST + k), 0);
         chk(rd, {24'h0, tbyte(k)});
      end
      apb(1, adr(`NBB_PAGE_RX, `NBB_OFS_FIRST), 32'hFF);
      chk({31'h0, err}, 0);
      apb(0, adr(`NBB_PAGE_RX, `NBB_OFS_FIRST), 0);
      chk(rd, 0);
      apb(0, adr(`NBB_PAGE_TX, 5'h15), 0);
      chk({31'h0, err}, 1);
      apb(1, adr(`NBB_PAGE_TX, `NBB_OFS_LAST) + 12'h2, 0);
      chk({31'h0, err}, 1);
      apb(0, adr(`NBB_PAGE_TX, `NBB_OFS_LAST), 0);
      chk(rd, {24'h0, tbyte(4)});
   endtask
   task automatic t_tx(input logic crc);
      logic [5:0] got;
      logic [4:0] exp;
      logic [7:0] b;
      if (!crc)
         do_reset;
      crc4_mf_active <= crc;
      for (int k = 0; k < `NBB_NUM_BYTES; k++)
         apb(1, adr(`NBB_PAGE_TX, `NBB_OFS_FIRST + k), {24'h0, tbyte(k)});
      apb(1, adr(`NBB_PAGE_CTRL, `NBB_OFS_CTRL), 1);
      apb(0, adr(`NBB_PAGE_CTRL, `NBB_OFS_STAT), 0);
      chk(rd, {31'h0, crc});
      for (int i = 0; i < 9; i++)
      begin
         framer_u.tx_frame(crc ? 4'(2 * (i % 8) + 1) : 4'hE, got);
         for (int k = 0; k < 5; k++)
         begin
            b = tbyte(k);
            exp[k] = b[7 - i % 8];
         end
         chk({26'h0, got}, {26'h0, 1'b1, exp});
      end
      apb(1, adr(`NBB_PAGE_CTRL, `NBB_OFS_CTRL), 0);
      framer_u.tx_frame(4'h1, got);
      chk({31'h0, got[5]}, 0);
   endtask
   task automatic t_rx(input logic crc);
      logic [7:0] exp [5];
      logic [4:0] p;
      if (!crc)
         do_reset;
      crc4_mf_active <= crc;
      for (int i = 0; i < 8; i++)
      begin
         p = 5'(i * 7 + 3);
         framer_u.rx_frame(crc ? 4'(2 * i + 1) : 4'h6, p);
         for (int k = 0; k < 5; k++)
            exp[k][7 - i] = p[k];
      end
      repeat (4) @(posedge clk_sys);
      for (int k = 0; k < 5; k++)
      begin
         apb(0, adr(`NBB_PAGE_RX, `NBB_OFS_FIRST + k), 0);
         chk(rd, {24'h0, exp[k]});
      end
   endtask
   // Reads of a receive byte stall the drain, so the FIFO fills
   task automatic t_fill;
      fork
         repeat (15)
            apb(0, adr(`NBB_PAGE_RX, `NBB_OFS_FIRST), 0, 1'b1);
         begin
            for (int i = 0; i < 15; i++)
               framer_u.rx_frame(4'h3, 5'(i));
            repeat (2) @(posedge clk_sys);
            chk({31'h0, rx_spare_ready}, 0);
         end
      join
      // Drain restarts at the setup edge, so one word has left when status is taken
      apb(0, adr(`NBB_PAGE_CTRL, `NBB_OFS_STAT), 0);
      chk(rd, 32'h0000_0E00);
      repeat (20) @(posedge clk_sys);
      apb(0, adr(`NBB_PAGE_CTRL, `NBB_OFS_STAT), 0);
      chk(rd, 0);
      chk({31'h0, rx_spare_ready}, 1);
   endtask
   task automatic end_sim;
      $display("Checks %0d, errors %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      @(posedge clk_sys);
      do_reset;
      t_regs;
      t_tx(1'b1);
      t_tx(1'b0);
      t_rx(1'b1);
      t_rx(1'b0);
      t_fill;
      end_sim;
   end
   initial
   begin
      #(5ns * 20000);
      fails++;
      end_sim;
   end
endmodule
`default_nettype wire
